// File: hdl/char_lcd_standard_cmds.sv
// Standard instruction page of a character LCD controller with text and
// pattern RAM, behind a Wishbone classic slave. Assumes a synchronous bus.
// What this block does
// - Home clears counter and display shift
// - Home leaves text RAM untouched
// - Home keeps step direction and shift mode
// - Entry instruction sets direction and shift mode
// - Data access steps counter by direction
// - Cursor hidden during pattern RAM access
// - Shift on text write per direction
// - No shift on reads or pattern access
// - Display control sets display and cursor
// - Display off grounds drive, keeps RAM
// - Outputs grounded within three cycles
// - Instructions still run while display off
// - Cursor drawn; stepping continues when hidden
// - Move instruction: shift or cursor, direction
// - Move touches no display data
// - Cursor wraps to next line past 40
// - Display shift moves all lines together
// - Counter unchanged for display shift only
// - Pattern load sets low six bits
// - Seven-bit shared counter, bit six kept
// - Text load sets all seven bits
// - Address loads and reads refresh read register
// - Busy flag refuses instructions while executing
// - Standard page decoded only when page zero
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module char_lcd_standard_cmds #(
  parameter int exec_len = lcd_cmd_pkg::exec_cycles
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic busy_o,
  output logic lcd_drive_en_o,
  output logic vgen_en_o,
  output logic cursor_vis_o,
  output logic [6:0] shift_pos_o,
  output logic [6:0] addr_o
);
  import lcd_cmd_pkg::*;

  // ==========================================================================
  // RAMs: 128 text cells and 64 pattern rows share one counter.
  // ==========================================================================
  logic [7:0] text_ram [0:127];
  logic [7:0] pattern_ram [0:63];
  core_t cur;
  core_t next_cur;
  logic req;
  logic [7:0] ins;
  logic [6:0] step_ac;
  logic [6:0] move_ac;
  logic [6:0] shift_l;
  logic [6:0] shift_r;
  logic [7:0] rd_now;

  assign req = cyc_i && stb_i && !cur.ack;
  assign ins = dat_i[7:0];

  function automatic logic [6:0] step_addr(input logic [6:0] a,
                                           input logic up,
                                           input logic two);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    // Each line is forty cells wide; the cursor jumps between lines.
    if (two && up && a == line_len - 7'h01)
      r = line2_base;
    else if (two && up && a == line2_base + line_len - 7'h01)
      r = reset_ac;
    else if (two && !up && a == line2_base)
      r = line_len - 7'h01;
    else if (two && !up && a == reset_ac)
      r = line2_base + line_len - 7'h01;
    return r;
  endfunction : step_addr

  always_comb
  begin
    step_ac = step_addr(cur.addr_counter, cur.addr_step_dir,
                        !cur.pattern_sel);
    move_ac = step_addr(cur.addr_counter, ins[2], 1'b1);
    // One offset for the whole screen keeps every line in step.
    shift_l = (cur.shift_pos == line_len - 7'h01) ? reset_ac
              : cur.shift_pos + 7'h01;
    shift_r = (cur.shift_pos == reset_ac) ? line_len - 7'h01
              : cur.shift_pos - 7'h01;
    rd_now = cur.pattern_sel ? pattern_ram[cur.addr_counter[5:0]]
             : text_ram[cur.addr_counter];
  end

  always_comb
  begin
    next_cur = cur;
    next_cur.ram_we = 1'b0;
    if (cur.ack)
      next_cur.ack = 1'b0;
    if (cur.busy_cnt != 4'h0)
      next_cur.busy_cnt = cur.busy_cnt - 4'h1;
    else
      next_cur.state = st_idle;
    // The drive stays on a few cycles after display off, then grounds.
    if (!cur.display_on && cur.off_cnt != 2'h0)
      next_cur.off_cnt = cur.off_cnt - 2'h1;
    next_cur.drive_en = cur.display_on
                        || (cur.off_cnt > 2'h1);
    next_cur.cursor_vis = cur.cursor_on && cur.display_on
                          && !cur.pattern_sel;
    if (cur.state == st_fetch)
      next_cur.read_reg = rd_now;
    if (req)
    begin
      next_cur.ack = 1'b1;
      next_cur.rdata = 32'h0;
      if (!we_i)
      begin
        if (adr_i == reg_status)
          next_cur.rdata = {23'h0, cur.instr_page_sel,
                            cur.state != st_idle,
                            cur.addr_counter};
        else if (adr_i == reg_data && cur.state == st_idle)
        begin
          next_cur.rdata = {24'h0, cur.read_reg};
          next_cur.addr_counter = step_ac;
          next_cur.state = st_fetch;
          next_cur.busy_cnt = 4'(exec_len);
        end
        else if (adr_i == reg_mode)
          next_cur.rdata = {28'h0, cur.display_on, cur.cursor_on,
                            cur.addr_step_dir, cur.shift_on_write};
      end
      else if (adr_i == reg_mode && sel_i[0])
        next_cur.instr_page_sel = dat_i[0];
      // Data and instruction writes while busy are acknowledged but dropped.
      else if (sel_i[0] && cur.state == st_idle
               && adr_i == reg_data)
      begin
        next_cur.ram_we = 1'b1;
        next_cur.ram_wdata = ins;
        next_cur.addr_counter = step_ac;
        next_cur.state = st_exec;
        next_cur.busy_cnt = 4'(exec_len);
        if (cur.shift_on_write && !cur.pattern_sel)
          next_cur.shift_pos = cur.addr_step_dir ? shift_l : shift_r;
      end
      else if (sel_i[0] && cur.state == st_idle
               && adr_i == reg_instr
               && !cur.instr_page_sel)
      begin
        next_cur.state = st_exec;
        next_cur.busy_cnt = 4'(exec_len);
        if (ins[7])
        begin
          next_cur.addr_counter = ins[6:0];
          next_cur.pattern_sel = 1'b0;
          next_cur.state = st_fetch;
        end
        else if (ins[7:6] == pat_code)
        begin
          next_cur.addr_counter[5:0] = ins[5:0];
          next_cur.pattern_sel = 1'b1;
          next_cur.state = st_fetch;
        end
        else if (ins[7:4] == move_code && ins[1:0] == 2'b00)
        begin
          if (ins[3])
            next_cur.shift_pos = ins[2] ? shift_r : shift_l;
          else
            next_cur.addr_counter = move_ac;
        end
        else if (ins[7:3] == disp_code && !ins[0])
        begin
          next_cur.display_on = ins[2];
          next_cur.cursor_on = ins[1];
          if (!ins[2])
            next_cur.off_cnt = 2'(off_cycles);
        end
        else if (ins[7:2] == entry_code)
        begin
          next_cur.addr_step_dir = ins[1];
          next_cur.shift_on_write = ins[0];
        end
        else if (ins == home_code)
        begin
          // Entry settings and RAM contents are left alone.
          next_cur.addr_counter = reset_ac;
          next_cur.shift_pos = reset_ac;
        end
      end
    end
  end

  // ==========================================================================
  // State and RAM write
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur <= '0;
      cur.addr_step_dir <= 1'b1;
      cur.state <= st_idle;
    end
    else if (ce_i)
      cur <= next_cur;
  end

  // Write at the pre-step address held in the previous cycle's counter.
  logic [6:0] wr_addr;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wr_addr <= reset_ac;
    else if (ce_i)
      wr_addr <= cur.addr_counter;
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i && cur.ram_we)
    begin
      if (cur.pattern_sel)
        pattern_ram[wr_addr[5:0]] <= cur.ram_wdata;
      else
        text_ram[wr_addr] <= cur.ram_wdata;
    end
  end

  assign dat_o = cur.rdata;
  assign ack_o = cur.ack;
  assign busy_o = cur.state != st_idle;
  assign lcd_drive_en_o = cur.drive_en;
  assign vgen_en_o = cur.drive_en;
  assign cursor_vis_o = cur.cursor_vis;
  assign shift_pos_o = cur.shift_pos;
  assign addr_o = cur.addr_counter;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_home;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && req && we_i && adr_i == reg_instr && sel_i[0]
       && dat_i[7:0] == home_code && cur.state == st_idle
       && !cur.instr_page_sel)
      |=> (cur.addr_counter == reset_ac && cur.shift_pos == reset_ac
           && cur.addr_step_dir == $past(cur.addr_step_dir));
  endproperty
  a_home: assert property (p_home) else $error("home failed");

  // The fall is seen one edge after the instruction is taken.
  property p_off;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && $fell(cur.display_on)) |-> ##3 !cur.drive_en;
  endproperty
  a_off: assert property (p_off) else $error("drive not off");

  property p_pat;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && req && we_i && adr_i == reg_instr && sel_i[0]
       && dat_i[7:6] == pat_code && cur.state == st_idle
       && !cur.instr_page_sel)
      |=> (cur.addr_counter[6] == $past(cur.addr_counter[6])
           && cur.pattern_sel);
  endproperty
  a_pat: assert property (p_pat) else $error("pattern load bad");

  property p_busy;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && cur.state != st_idle && req && we_i
       && adr_i == reg_instr) |=> $stable(cur.display_on);
  endproperty
  a_busy: assert property (p_busy) else $error("busy ignored");

  property p_curs;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && cur.pattern_sel |=> !cur.cursor_vis;
  endproperty
  a_curs: assert property (p_curs) else $error("cursor shown");

  property p_page;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && cur.instr_page_sel && req && adr_i == reg_instr)
      |=> $stable(cur.addr_counter);
  endproperty
  a_page: assert property (p_page) else $error("page ignored");

  property p_rdshift;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && req && !we_i && adr_i == reg_data)
      |=> $stable(cur.shift_pos);
  endproperty
  a_rdshift: assert property (p_rdshift) else $error("read shift");

  property p_drv;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && cur.display_on |=> cur.drive_en;
  endproperty
  a_drv: assert property (p_drv) else $error("drive off");

  property p_entry;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && req && we_i && adr_i == reg_instr && sel_i[0]
       && dat_i[7:2] == entry_code && cur.state == st_idle
       && !cur.instr_page_sel)
      |=> (cur.addr_step_dir == $past(dat_i[1])
           && cur.shift_on_write == $past(dat_i[0]));
  endproperty
  a_entry: assert property (p_entry) else $error("entry bad");

  property p_disp;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && req && we_i && adr_i == reg_instr && sel_i[0]
       && dat_i[7:3] == disp_code && !dat_i[0]
       && cur.state == st_idle && !cur.instr_page_sel)
      |=> (cur.display_on == $past(dat_i[2])
           && cur.cursor_on == $past(dat_i[1]));
  endproperty
  a_disp: assert property (p_disp) else $error("display bad");

  property p_move;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && req && we_i && adr_i == reg_instr && sel_i[0]
       && dat_i[7:4] == move_code && dat_i[1:0] == 2'b00 && dat_i[3]
       && cur.state == st_idle && !cur.instr_page_sel)
      |=> $stable(cur.addr_counter);
  endproperty
  a_move: assert property (p_move) else $error("shift moved");

  property p_wrshift;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && req && we_i && adr_i == reg_data && cur.pattern_sel)
      |=> $stable(cur.shift_pos);
  endproperty
  a_wrshift: assert property (p_wrshift) else $error("pat shift");

  // Pattern RAM has no line wrap, so an up step is a plain increment.
  property p_step;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && req && we_i && adr_i == reg_data && sel_i[0]
       && cur.state == st_idle && cur.pattern_sel && cur.addr_step_dir)
      |=> cur.addr_counter == $past(cur.addr_counter) + 7'h01;
  endproperty
  a_step: assert property (p_step) else $error("step bad");

endmodule : char_lcd_standard_cmds

// File: hdl/lcd_cmd_pkg.sv
// Shared constants and carrier types for the standard instruction decoder.
// Assumes a single 10 MHz clock and a Wishbone classic register port.
package lcd_cmd_pkg;

  // ==========================================================================
  // Register map (word addresses are byte offsets)
  // ==========================================================================
  localparam logic [3:0] reg_instr = 4'h0;
  localparam logic [3:0] reg_data = 4'h4;
  localparam logic [3:0] reg_status = 4'h8;
  localparam logic [3:0] reg_mode = 4'hc;

  // ==========================================================================
  // Field positions and fixed values
  // ==========================================================================
  localparam logic [7:0] home_code = 8'h02;
  localparam logic [5:0] entry_code = 6'h01;
  localparam logic [4:0] disp_code = 5'h01;
  localparam logic [3:0] move_code = 4'h1;
  localparam logic [1:0] pat_code = 2'h1;
  localparam int status_busy_bit = 7;
  localparam int status_page_bit = 8;
  localparam logic [6:0] line_len = 7'h28;
  localparam logic [6:0] line2_base = 7'h40;
  localparam logic [6:0] reset_ac = 7'h00;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int clk_mhz = 10;
  localparam int exec_ns = 400;
  localparam int exec_cycles = (exec_ns * clk_mhz + 999) / 1000;
  localparam int off_cycles = 3;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_exec = 3'b010,
    st_fetch = 3'b100
  } state_t;

  typedef struct packed {
    logic [6:0] addr_counter;
    logic [7:0] read_reg;
    logic [6:0] shift_pos;
    logic addr_step_dir;
    logic shift_on_write;
    logic display_on;
    logic cursor_on;
    logic pattern_sel;
    logic instr_page_sel;
    logic [3:0] busy_cnt;
    logic [1:0] off_cnt;
    logic drive_en;
    logic cursor_vis;
    logic ack;
    logic [31:0] rdata;
    logic ram_we;
    logic [7:0] ram_wdata;
    state_t state;
  } core_t;

endpackage : lcd_cmd_pkg

// File: testbench/lcd_host_model.sv
// Host bus master model that issues instruction and data bytes.
// Assumes a Wishbone classic slave on clk_i that answers with ack.
`timescale 1ns/1ps
module lcd_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [3:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  import lcd_cmd_pkg::*;
  int gap = 0;
  int hangs = 0;
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 4'h0;
    sel_o = 4'h1;
    dat_o = 32'h0;
  end
  // =====
  // Bus cycles
  // =====
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    repeat (gap + 1) @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    // Only the bench watchdog ends a wait for the answer.
    @(posedge clk_i);
    while (ack_i !== 1'b1)
      @(posedge clk_i);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released lines change so a late sample sees junk.
    adr_o <= ~a;
    dat_o <= ~d;
  endtask : wb
  task automatic idle();
    logic [31:0] s;
    int n;
    n = 0;
    s = 32'h80;
    while (s[status_busy_bit] !== 1'b0 && n < 50)
    begin
      wb(1'b0, reg_status, 32'h0, s);
      n++;
    end
    if (n == 50)
      hangs++;
  endtask : idle
  task automatic op(input logic [3:0] a, input logic w,
    input logic [7:0] d, output logic [31:0] q);
    idle();
    wb(w, a, {24'h0, d}, q);
    idle();
  endtask : op
endmodule : lcd_host_model

// File: testbench/tb_char_lcd_standard_cmds.sv
// Self-checking bench for the standard instruction decoder.
// Assumes the host model drives the bus; ce_i drops only in the busy test.
`timescale 1ns/1ps
module tb_char_lcd_standard_cmds;
  import lcd_cmd_pkg::*;
  logic clk_i, rst_i, ce, cyc, stb, we, ack, busy, drv, vgen, cur;
  logic [3:0] adr, sel;
  logic [31:0] wd, rd, q;
  logic [6:0] spos, addr;
  int err_count = 0;
  int n_tests = 0;
  char_lcd_standard_cmds i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd),
    .dat_o(rd), .ack_o(ack), .busy_o(busy), .lcd_drive_en_o(drv),
    .vgen_en_o(vgen), .cursor_vis_o(cur), .shift_pos_o(spos),
    .addr_o(addr));
  lcd_host_model i_host (
    .clk_i(clk_i), .ack_i(ack), .dat_i(rd), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
  // =====
  // Compare helpers
  // =====
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic ca(logic [6:0] e);
    cmp("addr", {25'h0, e}, {25'h0, addr});
  endtask : ca
  task automatic cf(string n, logic e, logic g);
    cmp(n, {31'h0, e}, {31'h0, g});
  endtask : cf
  task automatic ins(logic [7:0] b);
    i_host.op(reg_instr, 1'b1, b, q);
  endtask : ins
  // =====
  // Scenarios
  // =====
  task automatic t_shift();
    logic [6:0] s;
    i_host.op(reg_mode, 1'b0, 8'h0, q);
    cmp("mode", 32'h2, q & 32'hf);
    cf("drv", 1'b0, drv);
    ins(8'h07);
    ins(8'ha0);
    s = spos;
    i_host.op(reg_data, 1'b1, 8'ha5, q);
    ca(7'h21);
    cf("shifted", 1'b1, spos !== s);
    s = spos;
    ins(8'ha0);
    i_host.op(reg_data, 1'b0, 8'h0, q);
    cmp("rdata", 32'ha5, q);
    cf("kept", 1'b1, spos === s);
    ca(7'h21);
    ins(8'h02);
    ca(7'h00);
    cmp("shift", 32'h0, {25'h0, spos});
    i_host.op(reg_mode, 1'b0, 8'h0, q);
    cmp("mode", 32'h3, q & 32'h3);
    ins(8'ha0);
    i_host.op(reg_data, 1'b0, 8'h0, q);
    cmp("ram", 32'ha5, q);
  endtask : t_shift
  task automatic t_busy();
    i_host.wb(1'b1, reg_instr, 32'h91, q);
    cf("busy", 1'b1, busy);
    // A low clock enable must hold the countdown, so busy stays up.
    ce <= 1'b0;
    repeat (10) @(posedge clk_i);
    cf("frozen", 1'b1, busy);
    ce <= 1'b1;
    // Sent without polling, so it lands while busy and must be dropped.
    i_host.wb(1'b1, reg_instr, 32'ha2, q);
    i_host.op(reg_status, 1'b0, 8'h0, q);
    ca(7'h11);
    cmp("status", 32'h11, q & 32'h1ff);
    i_host.op(reg_mode, 1'b1, 8'h01, q);
    ins(8'h80);
    ca(7'h11);
    i_host.op(reg_mode, 1'b1, 8'h00, q);
  endtask : t_busy
  task automatic t_disp();
    logic [6:0] s;
    ins(8'h0e);
    cf("drv", 1'b1, drv);
    cf("cur", 1'b1, cur);
    i_host.wb(1'b1, reg_instr, 32'h08, q);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    cf("drv", 1'b0, drv);
    cf("vgen", 1'b0, vgen);
    ins(8'ha7);
    ca(7'h27);
    i_host.gap = 3;
    ins(8'h14);
    ca(7'h40);
    ins(8'h10);
    ca(7'h27);
    s = spos;
    ins(8'h18);
    ca(7'h27);
    cf("shifted", 1'b1, spos !== s);
    ins(8'h1c);
    cmp("back", {25'h0, s}, {25'h0, spos});
    i_host.gap = 0;
  endtask : t_disp
  task automatic t_pat();
    logic [6:0] s;
    ins(8'h0e);
    ins(8'hc0);
    ins(8'h45);
    ca(7'h45);
    cf("cur", 1'b0, cur);
    s = spos;
    i_host.op(reg_data, 1'b1, 8'h1f, q);
    ca(7'h46);
    cf("kept", 1'b1, spos === s);
    ins(8'h80);
    ins(8'h45);
    ca(7'h05);
    ins(8'h05);
    ins(8'hb0);
    i_host.op(reg_data, 1'b1, 8'h33, q);
    ca(7'h2f);
    cmp("shift", {25'h0, line_len - 7'h01}, {25'h0, spos});
    cf("cur", 1'b1, cur);
    i_host.op(reg_mode, 1'b0, 8'h0, q);
    cmp("mode", 32'hd, q & 32'hf);
  endtask : t_pat
  task automatic end_sim();
    err_count += i_host.hangs;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial
  begin
    rst_i = 1'b1;
    ce = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_shift();
    t_busy();
    t_disp();
    t_pat();
    end_sim();
  end
  initial
  begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    end_sim();
  end
endmodule : tb_char_lcd_standard_cmds
